// ==== seq_pkg.sv ====
// How it works
// - Links are played from the programmed last link (REG_LAST) downward, each link's segment in turn.
// - Every link names one segment; any segment may serve any number of links.
// - A link plays its segment as many whole times as its loop count; a count of zero plays it once.
// - Each link has an advance flag: zero continuous, one waits for a trigger.
// - Advance modes are automatic, stepped, single and mixed; automatic after reset.
// - Continuous run forbids single; triggered run forbids stepped and mixed.
// - A trigger source select picks the advancing trigger; automatic ignores it.
// - One sample per enabled clock, with no gap cycles between links or loops.
// - The sync marker fires on the chosen active segment and nothing else.
// - Apply copies the edit table into the live table and restarts output one cycle later.
// - Plain table edits reach the output only when sequencing is re-enabled.
// - After the last link the sequence wraps to the first and runs forever.
// - Automatic advance walks all links with no trigger, honouring loop counts.
// - Stepped advance repeats the current link until a trigger moves it on.
// - Single advance idles between links and plays on each trigger.
// - In single advance a triggered link runs all its loops before idling.
// - While idle the output holds the last sample that was produced.
// - In mixed advance a link flagged zero moves on automatically.
// - In mixed advance a link flagged one plays its loops then awaits a trigger.
// - Segments are found by start and stop tables; clearing them leaves samples intact.
package seq_pkg;
   localparam int LINK_AW = 4;
   localparam int NLINKS = 16;
   localparam int SEG_AW = 4;
   localparam int NSEGS = 16;
   localparam int LOOP_W = 8;
   localparam int MEM_AW = 10;
   localparam int SMP_W = 16;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 16;
   localparam int TRIG_N = 4;
   localparam int TSEL_W = 2;
   localparam int PIPE_N = 2;
   // Advance mode codes.
   localparam logic [1:0] ADV_AUTO = 2'h0;
   localparam logic [1:0] ADV_STEP = 2'h1;
   localparam logic [1:0] ADV_SINGLE = 2'h2;
   localparam logic [1:0] ADV_MIXED = 2'h3;
   // Register addresses; the upper nibble selects a table region.
   localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] REG_ACTIVE = 8'h01;
   localparam logic [ADDR_W-1:0] REG_APPLY = 8'h02;
   localparam logic [ADDR_W-1:0] REG_STATUS = 8'h03;
   localparam logic [ADDR_W-1:0] REG_LAST = 8'h04;
   localparam logic [ADDR_W-1:0] REG_SEGCLR = 8'h05;
   localparam logic [3:0] RGN_TAB = 4'h1;
   localparam logic [3:0] RGN_START = 4'h2;
   localparam logic [3:0] RGN_STOP = 4'h3;
   // Control register fields.
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_RUN_TRIG = 2;
   localparam int CTRL_TSEL_LSB = 3;
   localparam int CTRL_ENABLE = 5;
   // Reset values.
   localparam logic [LINK_AW-1:0] LAST_RST = 4'h0;
   localparam logic [SEG_AW-1:0] ACTIVE_RST = 4'h0;
   localparam logic [MEM_AW-1:0] ADDR_RST = 10'h000;
   localparam logic [SMP_W-1:0] SMP_RST = 16'h0000;
   // One link of the sequence table, as written to a table word.
   typedef struct packed {
      logic adv;
      logic [LOOP_W-1:0] loops;
      logic [SEG_AW-1:0] seg;
   } entry_t;
   localparam int ENT_W = 1 + LOOP_W + SEG_AW;
   // Output stream toward the converter.
   typedef struct packed {
      logic [SMP_W-1:0] sample;
      logic sync;
   } dac_out_t;
endpackage

// ==== seq_engine.sv ====
`timescale 1ns/100ps
module seq_engine
   import seq_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [DATA_W-1:0] rdata,
   input wire logic [TRIG_N-1:0] trig_in,
   output logic [MEM_AW-1:0] mem_addr,
   output logic mem_rd,
   input wire logic [SMP_W-1:0] mem_rdata,
   output dac_out_t dac,
   output logic pass_done
);
   typedef enum logic [1:0] {S_OFF, S_PLAY, S_WAIT} seq_state_t;

   seq_state_t st_r;
   logic [1:0] mode_r;
   logic run_trig_r;
   logic [TSEL_W-1:0] tsel_r;
   logic enable_r;
   logic [SEG_AW-1:0] active_r;
   logic [LINK_AW-1:0] last_r;
   logic restart_r;
   entry_t edit_tab [NLINKS];
   entry_t live_tab [NLINKS];
   logic [MEM_AW-1:0] seg_start [NSEGS];
   logic [MEM_AW-1:0] seg_stop [NSEGS];
   logic [LINK_AW-1:0] link_r;
   logic [LOOP_W-1:0] loop_r;
   logic [MEM_AW-1:0] addr_r;
   logic pend_r;
   logic [PIPE_N-1:0] valid_r;
   logic [PIPE_N-1:0] sync_r;
   logic [SMP_W-1:0] smp_r;
   logic [DATA_W-1:0] rdata_r;
   logic [TRIG_N-1:0] trig_rise;
   logic trig_ev;
   entry_t cur;
   entry_t nxt_ent;
   logic [LINK_AW-1:0] nxt_link;
   logic last_sample;
   logic loop_last;
   logic link_end;
   logic advance;
   logic to_wait;
   logic mode_ok;
   logic [1:0] wmode;
   logic wrun;
   logic sync_src;

   // Write strobes decoded by address.
   wire wr_ctrl = wr && (addr == REG_CTRL);
   wire wr_apply = wr && (addr == REG_APPLY);
   wire wr_tab = wr && (addr[7:4] == RGN_TAB);
   wire wr_start = wr && (addr[7:4] == RGN_START);
   wire wr_stop = wr && (addr[7:4] == RGN_STOP);
   wire wr_segclr = wr && (addr == REG_SEGCLR);

   // A mode that the run mode forbids is never stored; automatic is taken instead.
   always_comb begin
      wmode = wdata[CTRL_MODE_LSB +: 2];
      wrun = wdata[CTRL_RUN_TRIG];
      if (wrun) begin
         mode_ok = (wmode == ADV_AUTO) || (wmode == ADV_SINGLE);
      end else begin
         mode_ok = (wmode != ADV_SINGLE);
      end
   end

   // Control registers; automatic advance after reset.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         mode_r <= ADV_AUTO;
         run_trig_r <= 1'b0;
         tsel_r <= '0;
         enable_r <= 1'b0;
         active_r <= ACTIVE_RST;
         last_r <= LAST_RST;
      end else if (ce) begin
         if (wr_ctrl) begin
            mode_r <= mode_ok ? wmode : ADV_AUTO;
            run_trig_r <= wrun;
            tsel_r <= wdata[CTRL_TSEL_LSB +: TSEL_W];
            enable_r <= wdata[CTRL_ENABLE];
         end
         if (wr && (addr == REG_ACTIVE)) begin
            active_r <= wdata[SEG_AW-1:0];
         end
         if (wr && (addr == REG_LAST)) begin
            last_r <= wdata[LINK_AW-1:0];
         end
      end
   end

   // Restart one cycle after apply or after sequencing is switched on, so the
   // new control word is already in place when the first link is chosen.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         restart_r <= 1'b0;
      end else if (ce) begin
         restart_r <= wr_apply || (wr_ctrl && wdata[CTRL_ENABLE] && !enable_r);
      end
   end

   // Edit table and segment address tables. Clearing the segment tables
   // leaves the sample memory outside untouched.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         for (int i = 0; i < NLINKS; i++) begin
            edit_tab[i] <= '0;
         end
         for (int i = 0; i < NSEGS; i++) begin
            seg_start[i] <= ADDR_RST;
            seg_stop[i] <= ADDR_RST;
         end
      end else if (ce) begin
         if (wr_tab) begin
            edit_tab[addr[LINK_AW-1:0]] <= wdata[ENT_W-1:0];
         end
         if (wr_start) begin
            seg_start[addr[SEG_AW-1:0]] <= wdata[MEM_AW-1:0];
         end
         if (wr_stop) begin
            seg_stop[addr[SEG_AW-1:0]] <= wdata[MEM_AW-1:0];
         end
         if (wr_segclr) begin
            for (int i = 0; i < NSEGS; i++) begin
               seg_start[i] <= ADDR_RST;
               seg_stop[i] <= ADDR_RST;
            end
         end
      end
   end

   // Live table only changes on a restart, so edits do not disturb playback.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         for (int i = 0; i < NLINKS; i++) begin
            live_tab[i] <= '0;
         end
      end else if (ce && restart_r) begin
         live_tab <= edit_tab;
      end
   end

   // Trigger pins: three stages, an edge counts once stages two and three agree.
   generate
      for (genvar g = 0; g < TRIG_N; g++) begin : g_trig
         logic s1_r, s2_r, s3_r, lvl_r;
         always_ff @(posedge clk) begin
            if (!rst_n) begin
               s1_r <= 1'b0;
               s2_r <= 1'b0;
               s3_r <= 1'b0;
               lvl_r <= 1'b0;
            end else if (ce) begin
               s1_r <= trig_in[g];
               s2_r <= s1_r;
               s3_r <= s2_r;
               if (s2_r == s3_r) begin
                  lvl_r <= s3_r;
               end
            end
         end
         assign trig_rise[g] = (s2_r == s3_r) && s3_r && !lvl_r;
      end
   endgenerate

   // The selected trigger only matters outside automatic advance.
   assign trig_ev = trig_rise[tsel_r] && (mode_r != ADV_AUTO);

   // Link bookkeeping; the walk runs downward and wraps at link zero.
   always_comb begin
      cur = live_tab[link_r];
      nxt_link = (link_r == '0) ? last_r : link_r - 1'b1;
      nxt_ent = live_tab[nxt_link];
      last_sample = (addr_r == seg_stop[cur.seg]);
      // A loop count of zero plays once, the same as one.
      loop_last = ({1'b0, cur.loops} <= {1'b0, loop_r} + 9'h001);
      link_end = (st_r == S_PLAY) && last_sample && loop_last;
      advance = 1'b1;
      to_wait = 1'b0;
      case (mode_r)
         ADV_AUTO: advance = 1'b1;
         ADV_STEP: advance = pend_r;
         ADV_SINGLE: to_wait = 1'b1;
         ADV_MIXED: to_wait = cur.adv;
         default: advance = 1'b1;
      endcase
   end

   // Sequencer. Link and loop changes cost no cycle, so a pass lasts exactly
   // its total sample count in enabled clocks.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_r <= S_OFF;
         link_r <= '0;
         loop_r <= '0;
         addr_r <= ADDR_RST;
      end else if (ce) begin
         if (restart_r) begin
            link_r <= last_r;
            loop_r <= '0;
            addr_r <= seg_start[edit_tab[last_r].seg];
            st_r <= (mode_r == ADV_SINGLE) ? S_WAIT : S_PLAY;
         end else if (!enable_r) begin
            st_r <= S_OFF;
         end else begin
            case (st_r)
               S_PLAY: begin
                  if (!last_sample) begin
                     addr_r <= addr_r + 1'b1;
                  end else if (!loop_last) begin
                     loop_r <= loop_r + 1'b1;
                     addr_r <= seg_start[cur.seg];
                  end else begin
                     loop_r <= '0;
                     if (advance) begin
                        link_r <= nxt_link;
                        addr_r <= seg_start[nxt_ent.seg];
                     end else begin
                        addr_r <= seg_start[cur.seg];
                     end
                     if (to_wait) begin
                        st_r <= S_WAIT;
                     end
                  end
               end
               S_WAIT: begin
                  if (trig_ev) begin
                     st_r <= S_PLAY;
                  end
               end
               S_OFF: st_r <= S_OFF;
               default: st_r <= S_OFF;
            endcase
         end
      end
   end

   // Stepped trigger memory; a trigger in the cycle it is consumed is kept.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pend_r <= 1'b0;
      end else if (ce) begin
         if (restart_r) begin
            pend_r <= 1'b0;
         end else if (trig_ev && (mode_r == ADV_STEP) && (st_r == S_PLAY)) begin
            pend_r <= 1'b1;
         end else if (link_end && (mode_r == ADV_STEP)) begin
            pend_r <= 1'b0;
         end
      end
   end

   // Marker source: first sample of a link that plays the active segment.
   assign sync_src = (st_r == S_PLAY) && (cur.seg == active_r) && (loop_r == '0)
      && (addr_r == seg_start[cur.seg]);

   // Output pipeline matching the one-cycle memory read. The sample register
   // is only loaded by valid reads, so idle periods hold the last point.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         valid_r <= '0;
         sync_r <= '0;
         smp_r <= SMP_RST;
      end else if (ce) begin
         valid_r <= {valid_r[0], st_r == S_PLAY};
         sync_r <= {sync_r[0], sync_src};
         if (valid_r[0]) begin
            smp_r <= mem_rdata;
         end
      end
   end

   // Register read port, data in the cycle after the strobe.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rdata_r <= '0;
      end else if (ce) begin
         rdata_r <= '0;
         if (rd) begin
            if (addr == REG_CTRL) begin
               rdata_r <= {10'h000, enable_r, tsel_r, run_trig_r, mode_r};
            end else if (addr == REG_ACTIVE) begin
               rdata_r <= {12'h000, active_r};
            end else if (addr == REG_STATUS) begin
               rdata_r <= {2'h0, st_r, link_r, loop_r};
            end else if (addr == REG_LAST) begin
               rdata_r <= {12'h000, last_r};
            end else if (addr[7:4] == RGN_TAB) begin
               rdata_r <= {3'h0, edit_tab[addr[LINK_AW-1:0]]};
            end else if (addr[7:4] == RGN_START) begin
               rdata_r <= {6'h00, seg_start[addr[SEG_AW-1:0]]};
            end else if (addr[7:4] == RGN_STOP) begin
               rdata_r <= {6'h00, seg_stop[addr[SEG_AW-1:0]]};
            end
         end
      end
   end

   assign rdata = rdata_r;
   assign mem_addr = addr_r;
   assign mem_rd = (st_r == S_PLAY);
   assign dac.sample = smp_r;
   assign dac.sync = sync_r[1];
   assign pass_done = ce && link_end && advance && (link_r == '0);

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n || !ce);

   sequence s_restart;
      restart_r;
   endsequence
   sequence s_fresh;
      (link_r == last_r) && (loop_r == '0);
   endsequence

   property p_order;
      link_end && advance && (link_r != '0) && enable_r && !restart_r
         |=> link_r == $past(link_r) - 1'b1;
   endproperty
   a_order: assert property (p_order) else $error("link did not step down");

   property p_wrap;
      link_end && advance && (link_r == '0) && enable_r && !restart_r |=> link_r == last_r;
   endproperty
   a_wrap: assert property (p_wrap) else $error("sequence did not wrap");

   property p_loop;
      (st_r == S_PLAY) && last_sample && !loop_last && enable_r && !restart_r
         |=> (loop_r == $past(loop_r) + 1'b1) && $stable(link_r);
   endproperty
   a_loop: assert property (p_loop) else $error("loop count not applied");

   property p_mode_legal;
      run_trig_r ? (mode_r != ADV_STEP && mode_r != ADV_MIXED) : (mode_r != ADV_SINGLE);
   endproperty
   a_mode_legal: assert property (p_mode_legal) else $error("forbidden mode");

   property p_auto_run;
      (mode_r == ADV_AUTO) && (st_r == S_PLAY) && enable_r && !restart_r |=> st_r == S_PLAY;
   endproperty
   a_auto_run: assert property (p_auto_run) else $error("automatic stalled");

   property p_step_hold;
      link_end && (mode_r == ADV_STEP) && !pend_r && enable_r && !restart_r
         |=> $stable(link_r) && (st_r == S_PLAY);
   endproperty
   a_step_hold: assert property (p_step_hold) else $error("stepped moved alone");

   property p_single_idle;
      link_end && (mode_r == ADV_SINGLE) && enable_r && !restart_r |=> st_r == S_WAIT;
   endproperty
   a_single_idle: assert property (p_single_idle) else $error("single did not idle");

   property p_hold;
      (st_r == S_WAIT) [*3] |-> $stable(dac.sample);
   endproperty
   a_hold: assert property (p_hold) else $error("idle level moved");

   property p_mixed;
      link_end && (mode_r == ADV_MIXED) && enable_r && !restart_r
         |=> (st_r == S_WAIT) == $past(cur.adv);
   endproperty
   a_mixed: assert property (p_mixed) else $error("mixed flag ignored");

   property p_fresh;
      s_restart |=> s_fresh;
   endproperty
   a_fresh: assert property (p_fresh) else $error("restart not at first link");

   property p_sync;
      sync_src |-> ##2 dac.sync;
   endproperty
   a_sync: assert property (p_sync) else $error("marker missing");
endmodule

// ==== seq_mem_model.sv ====
`timescale 1ns/100ps
// Sample memory behind the engine; every word carries a fixed tag above its address.
module seq_mem_model
   import seq_pkg::*;
(
   input wire logic clk,
   input wire logic [MEM_AW-1:0] mem_addr,
   input wire logic mem_rd,
   output logic [SMP_W-1:0] mem_rdata
);
   initial mem_rdata = '0;
   // Data come one cycle after the read; an idle port toggles so a stale word never looks valid.
   always @(posedge clk) begin
      if (mem_rd) begin
         mem_rdata <= {6'h2a, mem_addr};
      end else begin
         mem_rdata <= ~mem_rdata;
      end
   end
endmodule

// ==== waveform_sequence_engine_bench.sv ====
`timescale 1ns/100ps
module waveform_sequence_engine_bench;
   import seq_pkg::*;
   logic clk, rst_n, ce, wr, rd, mem_rd, pass_done;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata, rdata;
   logic [TRIG_N-1:0] trig_in;
   logic [MEM_AW-1:0] mem_addr;
   logic [SMP_W-1:0] mem_rdata;
   dac_out_t dac;
   int miscompares = 0;
   int compares = 0;
   int cycles = 0;
   // One full pass of the test table: link 2 (two loops), link 1, link 0.
   logic [9:0] seq_a [0:10] = '{10'h010, 10'h011, 10'h012, 10'h010, 10'h011, 10'h012,
                                10'h020, 10'h021, 10'h010, 10'h011, 10'h012};
   logic [15:0] mode_in [0:2] = '{16'h0005, 16'h0002, 16'h0006};
   logic [15:0] mode_exp [0:2] = '{16'h0004, 16'h0000, 16'h0006};

   seq_engine dut (.clk(clk), .rst_n(rst_n), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata(rdata), .trig_in(trig_in), .mem_addr(mem_addr), .mem_rd(mem_rd),
      .mem_rdata(mem_rdata), .dac(dac), .pass_done(pass_done));
   seq_mem_model mem (.clk(clk), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_rdata(mem_rdata));

   // Free-running sample clock.
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   task automatic end_of_test();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // A hung handshake would otherwise stall the run forever.
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         miscompares++;
         end_of_test();
      end
   end

   task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   function automatic logic [15:0] smp(input logic [9:0] a);
      return {6'h2a, a};
   endfunction

   task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe, so they are taken there.
   task automatic rd_chk(input string name, input logic [7:0] a, input logic [15:0] exp,
                         input logic [15:0] mask);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      chk(name, rdata & mask, exp);
   endtask

   task automatic ent(input logic [3:0] l, input logic adv, input logic [7:0] lp,
                      input logic [3:0] sg);
      wr_reg({RGN_TAB, l}, {3'h0, adv, lp, sg});
   endtask

   // Segment 1 spans 0x010..0x012 and segment 2 spans 0x020..0x021.
   task automatic def_segs();
      for (int s = 1; s < 3; s++) begin
         wr_reg({RGN_START, 4'(s)}, 16'(s * 16));
         wr_reg({RGN_STOP, 4'(s)}, 16'(s * 16 + 3 - s));
      end
   endtask

   task automatic trig(input int b);
      @(posedge clk);
      trig_in[b] <= 1'b1;
      repeat (2) @(posedge clk);
      trig_in[b] <= 1'b0;
   endtask

   // Follows n consecutive stream cycles from table position first; no gap is tolerated.
   task automatic run_chk(input int n, input int first, input bit stop);
      int k;
      k = 0;
      @(negedge clk);
      while (mem_rd !== 1'b1 && k < 200) begin
         @(negedge clk);
         k++;
      end
      chk("stream start", 16'(mem_rd), 16'h0001);
      for (int i = 0; i < n; i++) begin
         chk("mem_addr", 16'(mem_addr), 16'(seq_a[(first + i) % 11]));
         chk("pass_done", 16'(pass_done), 16'((first + i) % 11 == 10));
         if (i >= 2) begin
            chk("sample", dac.sample, smp(seq_a[(first + i - 2) % 11]));
            chk("sync", 16'(dac.sync), 16'((first + i - 2) % 11 == 6));
         end
         @(negedge clk);
      end
      if (stop) begin
         chk("idle", 16'(mem_rd), 16'h0000);
      end
   endtask

   initial begin
      rst_n = 1'b0;
      ce = 1'b1;
      addr = '0;
      wdata = '0;
      wr = 1'b0;
      rd = 1'b0;
      trig_in = '0;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      rd_chk("ctrl reset", REG_CTRL, 16'h0000, 16'hffff);
      rd_chk("unmapped", 8'h7f, 16'h0000, 16'hffff);
      rd_chk("status reset", REG_STATUS, 16'h0000, 16'hffff);
      // Clearing the segment table and defining it again must leave the samples usable.
      def_segs();
      wr_reg(REG_SEGCLR, 16'h0000);
      def_segs();
      ent(4'h2, 1'b0, 8'h02, 4'h1);
      ent(4'h1, 1'b1, 8'h01, 4'h2);
      ent(4'h0, 1'b0, 8'h00, 4'h1);
      wr_reg(REG_LAST, 16'h0002);
      wr_reg(REG_ACTIVE, 16'h0002);
      for (int m = 0; m < 3; m++) begin
         wr_reg(REG_CTRL, mode_in[m]);
         rd_chk("ctrl mode", REG_CTRL, mode_exp[m], 16'hffff);
      end
      // Automatic advance: two whole passes with wrap and no trigger.
      wr_reg(REG_CTRL, 16'h0020);
      run_chk(22, 0, 1'b0);
      wr_reg(REG_CTRL, 16'h0000);
      // Stepped advance with trigger input 1 selected.
      wr_reg(REG_CTRL, 16'h0029);
      repeat (20) @(negedge clk);
      trig(0);
      repeat (30) @(negedge clk);
      rd_chk("step hold", REG_STATUS, 16'h0200, 16'h0f00);
      trig(1);
      repeat (30) @(negedge clk);
      rd_chk("step move", REG_STATUS, 16'h0100, 16'h0f00);
      wr_reg(REG_APPLY, 16'h0000);
      repeat (3) @(negedge clk);
      rd_chk("apply restart", REG_STATUS, 16'h0200, 16'h0f00);
      ent(4'h2, 1'b0, 8'h02, 4'h2);
      repeat (10) @(negedge clk);
      chk("edit pending", 16'(mem_addr[9:4]), 16'h0001);
      wr_reg(REG_APPLY, 16'h0000);
      repeat (5) @(negedge clk);
      chk("edit applied", 16'(mem_addr[9:4]), 16'h0002);
      ent(4'h2, 1'b0, 8'h02, 4'h1);
      wr_reg(REG_CTRL, 16'h0000);
      // Single advance in triggered run; re-entry also picks up the restored table.
      wr_reg(REG_CTRL, 16'h002e);
      repeat (10) @(negedge clk);
      rd_chk("single wait", REG_STATUS, 16'h2000, 16'h3000);
      chk("single idle", 16'(mem_rd), 16'h0000);
      trig(1);
      run_chk(6, 0, 1'b1);
      repeat (10) @(negedge clk);
      chk("idle level", dac.sample, smp(10'h012));
      wr_reg(REG_CTRL, 16'h0000);
      // Mixed advance: link 2 runs on, link 1 plays its loops and then waits.
      wr_reg(REG_CTRL, 16'h002b);
      run_chk(8, 0, 1'b1);
      repeat (3) @(negedge clk);
      rd_chk("mixed wait", REG_STATUS, 16'h2000, 16'h3000);
      trig(1);
      run_chk(9, 8, 1'b0);
      end_of_test();
   end
endmodule
